// file: rtl/bcast_decoder.sv
`timescale 1ns/10ps
`include "bcast_dec_consts.svh"

// ****************************************************************
// broadcast write, update and read command decoder
// ****************************************************************
module bcast_decoder (
  input  wire logic                        clock_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ce_i,
  input  wire logic                        narrow_i,
  input  wire logic                        frame_valid_i,
  input  wire logic [7:0]                  frame_cmd_i,
  input  wire logic [15:0]                 frame_data_i,
  input  wire logic                        chan_wr_i,
  input  wire bcast_dec_pkg::chan_wr_t     chan_wr_sel_i,
  input  wire logic [`ADDR_W-1:0]          chan_wr_addr_i,
  input  wire logic [`CODE_W-1:0]          chan_wr_data_i,
  input  wire logic [`CFG_W-1:0]           cfg_i,
  input  wire logic [`NUM_CH-1:0]          pd_i,
  input  wire logic [`NUM_CH-1:0]          ab_i,
  input  wire logic [`NUM_CH-1:0]          tb_i,
  input  wire logic [`NUM_CH-1:0]          en_i,
  input  wire logic [`MUX_W-1:0]           mux_i,
  input  wire logic [`FAULT_W-1:0]         fault_pin_i,
  input  wire logic [`TSD_W-1:0]           tsd_pin_i,
  output logic      [`NUM_CH*`CODE_W-1:0]  in_code_o,
  output logic      [`NUM_CH*`CODE_W-1:0]  out_code_o,
  output logic      [`NUM_CH*`SET_W-1:0]   settings_o,
  output logic                             read_valid_o,
  output logic      [15:0]                 read_data_o,
  output logic                             cmd_unknown_o
);

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire [3:0] hi = frame_cmd_i[7:4];
  wire [3:0] lo = frame_cmd_i[3:0];

  // every write strobe needs frame_valid_i; the no-op test does not, it only
  // carves 0xFF out of the unknown range
  wire do_code_all     = frame_valid_i & (frame_cmd_i == `CMD_CODE_ALL);
  wire do_code_all_upd = frame_valid_i & (frame_cmd_i == `CMD_CODE_ALL_UPD);
  wire do_set_all      = frame_valid_i & (frame_cmd_i == `CMD_SET_ALL);
  wire do_set_all_upd  = frame_valid_i & (frame_cmd_i == `CMD_SET_ALL_UPD);
  wire do_upd_all      = frame_valid_i & (frame_cmd_i == `CMD_UPD_ALL);
  wire is_nop          = frame_cmd_i == `CMD_NOP;

  wire is_rd_chan = (hi == `RD_CODE_HI) | (hi == `RD_SET_HI) |
                    (hi == `RD_OFS_HI) | (hi == `RD_GAIN_HI);
  wire is_rd_glob = (hi == `RD_GLOBAL_HI) & (lo <= `RD_TSD_LO);
  wire is_bcast   = (frame_cmd_i >= `CMD_CODE_ALL) & (frame_cmd_i <= `CMD_UPD_ALL);
  // other command ranges are decoded elsewhere; only the unlisted 0x7D..0x7F
  // and 0xF8..0xFE holes are flagged here
  wire is_hole    = ((frame_cmd_i > `CMD_UPD_ALL) & (hi == 4'h7)) |
                    ((hi == `RD_GLOBAL_HI) & (lo > `RD_TSD_LO) & !is_nop);

  // ****************************************************************
  // payload fields
  // ****************************************************************
  wire [`CODE_W-1:0] wide_code_field   = frame_data_i;
  wire [11:0]        narrow_code_field = frame_data_i[15:`NARROW_LSB];
  // narrow variant keeps its code right-aligned in the register
  wire [`CODE_W-1:0] bcast_code = narrow_i ? {4'h0, narrow_code_field}
                                           : wide_code_field;
  // settings word sits in frame bits 19:8, the low twelve bits of the payload
  wire [`SET_W-1:0]  bcast_set  = frame_data_i[`SET_W-1:0];

  // ****************************************************************
  // bank controls
  // ****************************************************************
  wire code_one  = chan_wr_i & (chan_wr_sel_i == bcast_dec_pkg::WR_CODE);
  wire set_one   = chan_wr_i & (chan_wr_sel_i == bcast_dec_pkg::WR_SET);
  wire ofs_one   = chan_wr_i & (chan_wr_sel_i == bcast_dec_pkg::WR_OFS);
  wire gain_one  = chan_wr_i & (chan_wr_sel_i == bcast_dec_pkg::WR_GAIN);
  wire code_all  = do_code_all | do_code_all_upd;
  // outputs take the new code directly so load and update land together
  wire out_all   = do_code_all_upd;
  wire out_copy  = do_upd_all | do_set_all_upd;
  wire set_all   = do_set_all | do_set_all_upd;

  wire [`ADDR_W-1:0] rd_addr = lo;
  wire [`CODE_W-1:0] in_rd;
  wire [`CODE_W-1:0] out_rd;
  wire [`SET_W-1:0]  set_rd;
  wire [`CODE_W-1:0] ofs_rd;
  wire [`CODE_W-1:0] gain_rd;
  wire [`NUM_CH*`CODE_W-1:0] ofs_all;
  wire [`NUM_CH*`CODE_W-1:0] gain_all;

  // ****************************************************************
  // per-channel storage
  // ****************************************************************
  channel_bank #(.W(`CODE_W)) u_in_bank (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .wr_one_i    (code_one),
    .wr_all_i    (code_all),
    .wr_addr_i   (chan_wr_addr_i),
    .wr_data_i   (code_all ? bcast_code : chan_wr_data_i),
    .copy_i      (1'b0),
    .copy_data_i ('0),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (in_rd),
    .all_o       (in_code_o)
  );

  // output bank: only broadcast loads and whole-bank copies reach it
  channel_bank #(.W(`CODE_W)) u_out_bank (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .wr_one_i    (1'b0),
    .wr_all_i    (out_all),
    .wr_addr_i   (chan_wr_addr_i),
    .wr_data_i   (bcast_code),
    .copy_i      (out_copy),
    .copy_data_i (in_code_o),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (out_rd),
    .all_o       (out_code_o)
  );

  channel_bank #(.W(`SET_W)) u_set_bank (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .wr_one_i    (set_one),
    .wr_all_i    (set_all),
    .wr_addr_i   (chan_wr_addr_i),
    .wr_data_i   (set_all ? bcast_set : chan_wr_data_i[`SET_W-1:0]),
    .copy_i      (1'b0),
    .copy_data_i ('0),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (set_rd),
    .all_o       (settings_o)
  );

  channel_bank #(.W(`CODE_W)) u_ofs_bank (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .wr_one_i    (ofs_one),
    .wr_all_i    (1'b0),
    .wr_addr_i   (chan_wr_addr_i),
    .wr_data_i   (chan_wr_data_i),
    .copy_i      (1'b0),
    .copy_data_i ('0),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (ofs_rd),
    .all_o       (ofs_all)
  );

  channel_bank #(.W(`CODE_W)) u_gain_bank (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .wr_one_i    (gain_one),
    .wr_all_i    (1'b0),
    .wr_addr_i   (chan_wr_addr_i),
    .wr_data_i   (chan_wr_data_i),
    .copy_i      (1'b0),
    .copy_data_i ('0),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (gain_rd),
    .all_o       (gain_all)
  );

  // ****************************************************************
  // status pins from outside the clock domain
  // ****************************************************************
  // a glitch shorter than one clock never reaches the fault or thermal read
  wire [`FAULT_W-1:0] fault_lvl;
  wire [`TSD_W-1:0]   tsd_lvl;

  pin_sync #(.W(`FAULT_W)) u_fault_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .pin_i   (fault_pin_i),
    .level_o (fault_lvl)
  );

  pin_sync #(.W(`TSD_W)) u_tsd_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .pin_i   (tsd_pin_i),
    .level_o (tsd_lvl)
  );

  // ****************************************************************
  // read source selection, stage one
  // ****************************************************************
  // global words are sampled at the frame edge so a later change cannot leak in
  bcast_dec_pkg::rd_src_t src_next;
  bcast_dec_pkg::rd_src_t src_reg;
  logic [15:0]            glob_next;
  logic [15:0]            glob_reg;

  always_comb begin
    src_next  = bcast_dec_pkg::SRC_NONE;
    glob_next = 16'h0000;
    if (frame_valid_i) begin
      case (hi)
        `RD_CODE_HI: src_next = bcast_dec_pkg::SRC_CODE;
        `RD_SET_HI:  src_next = bcast_dec_pkg::SRC_SET;
        `RD_OFS_HI:  src_next = bcast_dec_pkg::SRC_OFS;
        `RD_GAIN_HI: src_next = bcast_dec_pkg::SRC_GAIN;
        `RD_GLOBAL_HI: begin
          case (lo)
            `RD_CFG_LO: begin
              src_next  = bcast_dec_pkg::SRC_CFG;
              glob_next = {13'h0, cfg_i};
            end
            `RD_PD_LO: begin
              src_next  = bcast_dec_pkg::SRC_PD;
              glob_next = pd_i;
            end
            `RD_AB_LO: begin
              src_next  = bcast_dec_pkg::SRC_AB;
              glob_next = ab_i;
            end
            `RD_TB_LO: begin
              src_next  = bcast_dec_pkg::SRC_TB;
              glob_next = tb_i;
            end
            `RD_EN_LO: begin
              src_next  = bcast_dec_pkg::SRC_EN;
              glob_next = en_i;
            end
            `RD_MUX_LO: begin
              src_next  = bcast_dec_pkg::SRC_MUX;
              glob_next = {5'h0, mux_i};
            end
            `RD_FAULT_LO: begin
              src_next  = bcast_dec_pkg::SRC_FAULT;
              glob_next = {13'h0, fault_lvl};
            end
            `RD_TSD_LO: begin
              src_next  = bcast_dec_pkg::SRC_TSD;
              glob_next = tsd_lvl;
            end
            default: src_next = bcast_dec_pkg::SRC_NONE;
          endcase
        end
        default: src_next = bcast_dec_pkg::SRC_NONE;
      endcase
    end
  end

  // ****************************************************************
  // corrected code: out * (1 + gain/2^16) + offset, clamped
  // ****************************************************************
  // math runs on the bank's registered word, so only one multiplier is needed
  // limitation: a result below zero clamps silently, with no flag raised
  wire signed [17:0] gain_fac = `UNITY_GAIN + {{2{gain_rd[15]}}, gain_rd};
  wire signed [17:0] code_s   = {2'b00, out_rd};
  wire signed [35:0] prod     = code_s * gain_fac;
  wire signed [18:0] adj_sum  = {prod[34], prod[33:16]} + {{3{ofs_rd[15]}}, ofs_rd};
  wire [15:0] adj_code = adj_sum[18] ? 16'h0000 :
                         (adj_sum[17:16] != 2'b00) ? 16'hFFFF : adj_sum[15:0];

  // ****************************************************************
  // read answer, stage two
  // ****************************************************************
  // the answer is chosen one cycle after the frame, when the banks' registered
  // read words for the addressed channel have settled
  wire [15:0] ans =
    (src_reg == bcast_dec_pkg::SRC_CODE) ? adj_code :
    (src_reg == bcast_dec_pkg::SRC_SET)  ? {4'h0, set_rd} :
    (src_reg == bcast_dec_pkg::SRC_OFS)  ? ofs_rd :
    (src_reg == bcast_dec_pkg::SRC_GAIN) ? gain_rd : glob_reg;

  // stage one registers: source and the global word captured with the frame
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_reg  <= bcast_dec_pkg::SRC_NONE;
      glob_reg <= 16'h0000;
    end else if (ce_i) begin
      src_reg  <= src_next;
      glob_reg <= glob_next;
    end
  end

  // answer and unknown-command flag
  // the flag is a one-cycle pulse, so it needs no clear and cannot stick
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      read_valid_o  <= 1'b0;
      read_data_o   <= 16'h0000;
      cmd_unknown_o <= 1'b0;
    end else if (ce_i) begin
      read_valid_o  <= src_reg != bcast_dec_pkg::SRC_NONE;
      read_data_o   <= (src_reg != bcast_dec_pkg::SRC_NONE) ? ans : 16'h0000;
      cmd_unknown_o <= frame_valid_i & is_hole & !is_bcast & !is_rd_chan & !is_rd_glob;
    end
  end

endmodule

// file: shared/bcast_dec_consts.svh
`ifndef BCAST_DEC_CONSTS_SVH
`define BCAST_DEC_CONSTS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define NUM_CH        16
`define ADDR_W        4
`define CODE_W        16
`define SET_W         12
`define CFG_W         3
`define MUX_W         11
`define FAULT_W       3
`define TSD_W         16

// ****************************************************************
// command codes
// ****************************************************************
`define CMD_CODE_ALL      8'h78
`define CMD_CODE_ALL_UPD  8'h79
`define CMD_SET_ALL       8'h7A
`define CMD_SET_ALL_UPD   8'h7B
`define CMD_UPD_ALL       8'h7C
`define CMD_NOP           8'hFF
`define RD_CODE_HI        4'h8
`define RD_SET_HI         4'h9
`define RD_OFS_HI         4'hA
`define RD_GAIN_HI        4'hB
`define RD_GLOBAL_HI      4'hF
`define RD_CFG_LO         4'h0
`define RD_PD_LO          4'h1
`define RD_AB_LO          4'h2
`define RD_TB_LO          4'h3
`define RD_EN_LO          4'h4
`define RD_MUX_LO         4'h5
`define RD_FAULT_LO       4'h6
`define RD_TSD_LO         4'h7

// ****************************************************************
// reset values and field slices
// ****************************************************************
`define CODE_RST      16'h0000
`define SET_RST       12'h000
`define NARROW_LSB    4
`define UNITY_GAIN    18'sh10000

`endif

// file: shared/bcast_dec_pkg.sv
package bcast_dec_pkg;

  // where a read answer is taken from
  typedef enum logic [3:0] {
    SRC_NONE,
    SRC_CODE,
    SRC_SET,
    SRC_OFS,
    SRC_GAIN,
    SRC_CFG,
    SRC_PD,
    SRC_AB,
    SRC_TB,
    SRC_EN,
    SRC_MUX,
    SRC_FAULT,
    SRC_TSD
  } rd_src_t;

  // target of a single-channel write from the per-channel decoder
  typedef enum logic [1:0] {
    WR_CODE,
    WR_SET,
    WR_OFS,
    WR_GAIN
  } chan_wr_t;

endpackage

// file: rtl/channel_bank.sv
`timescale 1ns/10ps
`include "bcast_dec_consts.svh"

// ****************************************************************
// one register per channel, with single, broadcast and copy loads
// ****************************************************************
module channel_bank #(
  parameter int W = 16
) (
  input  wire logic                  clock_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  input  wire logic                  wr_one_i,
  input  wire logic                  wr_all_i,
  input  wire logic [`ADDR_W-1:0]    wr_addr_i,
  input  wire logic [W-1:0]          wr_data_i,
  input  wire logic                  copy_i,
  input  wire logic [`NUM_CH*W-1:0]  copy_data_i,
  input  wire logic [`ADDR_W-1:0]    rd_addr_i,
  output logic      [W-1:0]          rd_data_o,
  output logic      [`NUM_CH*W-1:0]  all_o
);

  // broadcast wins over a single write; copy is lowest
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : gen_entry
      wire hit = wr_all_i | (wr_one_i & (wr_addr_i == `ADDR_W'(g)));
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          all_o[g*W +: W] <= '0;
        end else if (ce_i) begin
          if (hit) begin
            all_o[g*W +: W] <= wr_data_i;
          end else if (copy_i) begin
            all_o[g*W +: W] <= copy_data_i[g*W +: W];
          end
        end
      end
    end
  endgenerate

  // read data registered: one cycle from address to data
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= '0;
    end else if (ce_i) begin
      rd_data_o <= all_o[rd_addr_i*W +: W];
    end
  end

endmodule

// file: rtl/pin_sync.sv
`timescale 1ns/10ps

// ****************************************************************
// three-stage pin synchroniser, accepts a change once stages agree
// ****************************************************************
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic          clock_i,
  input  wire logic          rstn_i,
  input  wire logic          ce_i,
  input  wire logic [W-1:0]  pin_i,
  output logic      [W-1:0]  level_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // meta_reg feeds only s2_reg; filtering looks at s2/s3 only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      level_o  <= '0;
    end else if (ce_i) begin
      meta_reg <= pin_i;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
      level_o  <= (s2_reg & s3_reg) | (level_o & (s2_reg | s3_reg));
    end
  end

endmodule

// file: dv/host_model.sv
`timescale 1ns/10ps

// ****************************************************************
// frame source standing in for the serial host controller
// ****************************************************************
module host_model (
  input  wire logic         clock_i,
  output logic              frame_valid_o,
  output logic      [7:0]   frame_cmd_o,
  output logic      [15:0]  frame_data_o
);
  // idle state before the first frame
  initial begin
    frame_valid_o = 1'b0;
    frame_cmd_o   = 8'h00;
    frame_data_o  = 16'h0000;
  end

  // one whole frame per call, launched off the falling edge
  // released lines show the inverse so a stale value can never pass as a match
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock_i);
    frame_valid_o = 1'b1;
    frame_cmd_o   = c;
    frame_data_o  = d;
    @(negedge clock_i);
    frame_valid_o = 1'b0;
    frame_cmd_o   = ~c;
    frame_data_o  = ~d;
  endtask
endmodule

// file: dv/bcast_decoder_asserts.sv
`timescale 1ns/10ps
`include "bcast_dec_consts.svh"

// ****************************************************************
// port checker for the broadcast decoder
// ****************************************************************
module bcast_decoder_asserts (
  input  wire logic                        clock_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ce_i,
  input  wire logic                        narrow_i,
  input  wire logic                        frame_valid_i,
  input  wire logic [7:0]                  frame_cmd_i,
  input  wire logic [15:0]                 frame_data_i,
  input  wire logic                        chan_wr_i,
  input  wire logic [`NUM_CH-1:0]          tb_i,
  input  wire logic [`NUM_CH*`CODE_W-1:0]  in_code_o,
  input  wire logic [`NUM_CH*`CODE_W-1:0]  out_code_o,
  input  wire logic [`NUM_CH*`SET_W-1:0]   settings_o,
  input  wire logic                        read_valid_o,
  input  wire logic [15:0]                 read_data_o,
  input  wire logic                        cmd_unknown_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // frame taken, the code as the variant reads it, and read decode
  wire              take  = ce_i & frame_valid_i;
  wire       [15:0] bcode = narrow_i ? {4'h0, frame_data_i[15:4]} : frame_data_i;
  wire              rd_hi = frame_cmd_i[7:4] inside {4'h8, 4'h9, 4'hA, 4'hB};
  wire              rd_gl = frame_cmd_i inside {[8'hF0:8'hF7]};
  wire              bad   = frame_cmd_i inside {[8'h7D:8'h7F], [8'hF8:8'hFE]};

  a_code_load: assert property (
    take && frame_cmd_i == 8'h78 |=> in_code_o == {16{$past(bcode)}} && $stable(out_code_o))
    else $error("broadcast code load wrong");
  a_code_update: assert property (
    take && frame_cmd_i == 8'h79 |=> in_code_o == {16{$past(bcode)}} && out_code_o == in_code_o)
    else $error("broadcast code with update wrong");
  a_set_load: assert property (
    take && frame_cmd_i == 8'h7A |=> settings_o == {16{$past(frame_data_i[11:0])}})
    else $error("broadcast settings load wrong");
  a_set_update: assert property (
    take && frame_cmd_i == 8'h7B |=> settings_o == {16{$past(frame_data_i[11:0])}}
      && out_code_o == $past(in_code_o))
    else $error("settings with update wrong");
  a_update_all: assert property (
    take && frame_cmd_i == 8'h7C |=> out_code_o == $past(in_code_o))
    else $error("update all wrong");
  a_quiet_cmd: assert property (
    take && (frame_cmd_i == 8'hFF || bad) && !chan_wr_i
      |=> $stable(in_code_o) && $stable(out_code_o) && $stable(settings_o))
    else $error("no-op or unknown code changed state");
  a_unknown_flag: assert property (
    take && bad |-> ##[1:2] cmd_unknown_o)
    else $error("unknown code not flagged");
  a_read_timing: assert property (
    take && (rd_hi || rd_gl) ##1 ce_i |=> read_valid_o)
    else $error("read answer not on time");
  a_toggle_read: assert property (
    take && frame_cmd_i == 8'hF3 ##1 ce_i |=> read_data_o == $past(tb_i, 2))
    else $error("toggle bit read wrong");

  // main scenarios reached
  c_set_update: cover property (take && frame_cmd_i == 8'h7B);
  c_read:       cover property (read_valid_o);
  c_unknown:    cover property (cmd_unknown_o);
endmodule

bind bcast_decoder bcast_decoder_asserts i_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .narrow_i(narrow_i),
  .frame_valid_i(frame_valid_i), .frame_cmd_i(frame_cmd_i), .frame_data_i(frame_data_i),
  .chan_wr_i(chan_wr_i), .tb_i(tb_i), .in_code_o(in_code_o), .out_code_o(out_code_o),
  .settings_o(settings_o), .read_valid_o(read_valid_o), .read_data_o(read_data_o),
  .cmd_unknown_o(cmd_unknown_o)
);

// file: dv/tb_top.sv
`timescale 1ns/10ps
`include "bcast_dec_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, got); end end

module tb_top;
  logic                     clock_i, rstn_i, ce_i, narrow_i, chan_wr_i;
  logic                     frame_valid_i, read_valid_o, cmd_unknown_o;
  logic [7:0]               frame_cmd_i;
  logic [15:0]              frame_data_i, chan_wr_data_i, read_data_o;
  bcast_dec_pkg::chan_wr_t  chan_wr_sel_i;
  logic [3:0]               chan_wr_addr_i;
  logic [2:0]               cfg_i, fault_pin_i;
  logic [15:0]              pd_i, ab_i, tb_i, en_i, tsd_pin_i;
  logic [10:0]              mux_i;
  logic [255:0]             in_code_o, out_code_o;
  logic [191:0]             settings_o;
  int                       error_cnt, n_checks;

  host_model i_host (.clock_i(clock_i), .frame_valid_o(frame_valid_i),
    .frame_cmd_o(frame_cmd_i), .frame_data_o(frame_data_i));

  bcast_decoder i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .narrow_i(narrow_i),
    .frame_valid_i(frame_valid_i), .frame_cmd_i(frame_cmd_i), .frame_data_i(frame_data_i),
    .chan_wr_i(chan_wr_i), .chan_wr_sel_i(chan_wr_sel_i), .chan_wr_addr_i(chan_wr_addr_i),
    .chan_wr_data_i(chan_wr_data_i), .cfg_i(cfg_i), .pd_i(pd_i), .ab_i(ab_i), .tb_i(tb_i),
    .en_i(en_i), .mux_i(mux_i), .fault_pin_i(fault_pin_i), .tsd_pin_i(tsd_pin_i),
    .in_code_o(in_code_o), .out_code_o(out_code_o), .settings_o(settings_o),
    .read_valid_o(read_valid_o), .read_data_o(read_data_o), .cmd_unknown_o(cmd_unknown_o));

  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // single-channel write pulse, as the per-channel decoder would give it
  task automatic chan_write(input bcast_dec_pkg::chan_wr_t s, input logic [3:0] a,
                            input logic [15:0] d);
    @(negedge clock_i);
    chan_wr_i = 1'b1;
    chan_wr_sel_i = s;
    chan_wr_addr_i = a;
    chan_wr_data_i = d;
    @(negedge clock_i);
    chan_wr_i = 1'b0;
  endtask

  // read frame, then wait a bounded time for the answer pulse
  task automatic do_read(input logic [7:0] c, input logic [15:0] ex);
    int i;
    i_host.send(c, 16'h0000);
    for (i = 0; i < 4 && read_valid_o !== 1'b1; i++) @(negedge clock_i);
    `CHK("read_valid_o", 1'b1, read_valid_o)
    `CHK("read_data_o", ex, read_data_o)
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_code_all();
    i_host.send(8'h78, 16'hA5C3);
    `CHK("in_code_o", {16{16'hA5C3}}, in_code_o)
    `CHK("out_code_o", 256'h0, out_code_o)
    i_host.send(8'h7C, 16'h0000);
    `CHK("out_code_o", {16{16'hA5C3}}, out_code_o)
  endtask

  task automatic t_narrow();
    narrow_i = 1'b1;
    i_host.send(8'h78, 16'h1234);
    `CHK("in_code_o narrow", {16{16'h0123}}, in_code_o)
    i_host.send(8'h79, 16'hABCD);
    `CHK("in_code_o", {16{16'h0ABC}}, in_code_o)
    `CHK("out_code_o", {16{16'h0ABC}}, out_code_o)
    narrow_i = 1'b0;
  endtask

  // a pending single-channel code must reach the output on the update form; other channels keep theirs
  task automatic t_settings();
    i_host.send(8'h7A, 16'h1234);
    `CHK("settings_o", {16{12'h234}}, settings_o)
    `CHK("out_code_o", {16{16'h0ABC}}, out_code_o)
    chan_write(bcast_dec_pkg::WR_CODE, 4'h5, 16'h4321);
    i_host.send(8'h7B, 16'h0567);
    `CHK("settings_o", {16{12'h567}}, settings_o)
    `CHK("out_code_o ch5", 16'h4321, out_code_o[95:80])
    `CHK("out_code_o ch0", 16'h0ABC, out_code_o[15:0])
  endtask

  task automatic t_reads();
    logic [15:0] ex [8];
    int k;
    ex = '{16'h0006, 16'h0F01, 16'h00F2, 16'hA003, 16'h1234, 16'h0555, 16'h0005, 16'hC33C};
    do_read(8'h93, 16'h0567);
    chan_write(bcast_dec_pkg::WR_OFS, 4'h4, 16'h0005);
    do_read(8'hA4, 16'h0005);
    do_read(8'h84, 16'h0AC1);
    chan_write(bcast_dec_pkg::WR_GAIN, 4'h1, 16'h1234);
    do_read(8'hB1, 16'h1234);
    do_read(8'h81, 16'h0B7F);
    for (k = 0; k < 8; k++) begin
      do_read(8'hF0 + 8'(k), ex[k]);
    end
  endtask

  task automatic t_quiet();
    int i;
    i_host.send(8'hFF, 16'hFFFF);
    `CHK("in_code_o", {15{16'h0ABC}}, {in_code_o[255:96], in_code_o[79:0]})
    `CHK("settings_o", {16{12'h567}}, settings_o)
    i_host.send(8'h7D, 16'h1111);
    for (i = 0; i < 3 && cmd_unknown_o !== 1'b1; i++) @(negedge clock_i);
    `CHK("cmd_unknown_o", 1'b1, cmd_unknown_o)
    `CHK("out_code_o", 16'h4321, out_code_o[95:80])
    // a frame met with the clock enable low must not be taken
    ce_i = 1'b0;
    i_host.send(8'h78, 16'h1111);
    `CHK("in_code_o frozen", 16'h0ABC, in_code_o[15:0])
    ce_i = 1'b1;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    error_cnt = 0;
    n_checks = 0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    narrow_i = 1'b0;
    chan_wr_i = 1'b0;
    chan_wr_sel_i = bcast_dec_pkg::WR_CODE;
    chan_wr_addr_i = 4'h0;
    chan_wr_data_i = 16'h0000;
    cfg_i = 3'h6;
    pd_i = 16'h0F01;
    ab_i = 16'h00F2;
    tb_i = 16'hA003;
    en_i = 16'h1234;
    mux_i = 11'h555;
    fault_pin_i = 3'h5;
    tsd_pin_i = 16'hC33C;
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    t_code_all();
    t_narrow();
    t_settings();
    t_reads();
    t_quiet();
    print_verdict();
  end

  // the whole run needs some 67 cycles; 4000 leaves ample margin
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
endmodule
